/* logic/azl_acc_unit.sv */
`timescale 1ns/1ps
`include "azl_map.svh"

// Summary of operation
// - high load copies word into bits 31-16
// - high load clears bits 15-0 together
// - direct offset 0-127; indirect optional new pointer
// - low load puts word into bits 15-0
// - low load forces bits 31-16 to zero
// - low load never sign-extends, ignores mode bit
module azl_acc_unit (
    input  wire logic                       core_clk,
    input  wire logic                       reset_n,
    input  wire logic                       op_valid,
    output logic                            op_ready,
    input  wire azl_pkg::azl_op_t           op_code,
    input  wire logic                       op_indirect,
    input  wire logic [`AZL_DMA_W-1:0]      op_offset,
    input  wire azl_pkg::azl_ind_t          op_ind_mode,
    input  wire logic                       op_arp_load,
    input  wire logic [`AZL_ARP_W-1:0]      op_arp_new,
    input  wire logic [`AZL_PAGE_W-1:0]     page_ptr,
    input  wire logic                       sign_extend_mode,
    input  wire logic                       ar_wr_en,
    input  wire logic [`AZL_ARP_W-1:0]      ar_wr_sel,
    input  wire logic [`AZL_DADDR_W-1:0]    ar_wr_data,
    input  wire logic                       mem_wr_en,
    input  wire logic [`AZL_MEM_AW-1:0]     mem_wr_addr,
    input  wire logic [`AZL_WORD_W-1:0]     mem_wr_data,
    output logic                            op_done,
    output logic      [`AZL_ACC_W-1:0]      acc,
    output logic      [`AZL_PC_W-1:0]       pc,
    output logic      [`AZL_ARP_W-1:0]      arp,
    output logic      [`AZL_DADDR_W-1:0]    ar_value
);
    import azl_pkg::*;

    azl_state_t                 state_r, state_nxt;
    azl_op_t                    op_r, op_nxt;
    logic [`AZL_ACC_W-1:0]      acc_r, acc_nxt;
    logic [`AZL_PC_W-1:0]       pc_r, pc_nxt;
    logic [`AZL_ARP_W-1:0]      arp_r, arp_nxt;
    logic [`AZL_DADDR_W-1:0]    ar_r [0:`AZL_AR_NUM-1];
    logic [`AZL_DADDR_W-1:0]    ar_nxt [0:`AZL_AR_NUM-1];
    logic                       done_r, done_nxt;
    logic [`AZL_DADDR_W-1:0]    addr_nxt;
    logic [`AZL_MEM_AW-1:0]     rd_addr_r, rd_addr_nxt;
    logic [`AZL_WORD_W-1:0]     rd_word;

    // next value of the current pointer register after an indirect access
    function automatic logic [`AZL_DADDR_W-1:0] ar_step(
        input logic [`AZL_DADDR_W-1:0] cur,
        input logic [`AZL_DADDR_W-1:0] idx,
        input azl_ind_t                mode
    );
        unique case (mode)
            AZL_IND_INC:  ar_step = cur + `AZL_PC_STEP;
            AZL_IND_DEC:  ar_step = cur - `AZL_PC_STEP;
            AZL_IND_INC0: ar_step = cur + idx;
            AZL_IND_DEC0: ar_step = cur - idx;
            default:      ar_step = cur;
        endcase
    endfunction

    azl_data_ram u_ram (
        .core_clk (core_clk),
        .wr_en    (mem_wr_en),
        .wr_addr  (mem_wr_addr),
        .wr_data  (mem_wr_data),
        .rd_addr  (rd_addr_r),
        .rd_data  (rd_word)
    );

    assign op_ready = (state_r == AZL_ST_IDLE);
    assign op_done  = done_r;
    assign acc      = acc_r;
    assign pc       = pc_r;
    assign arp      = arp_r;
    assign ar_value = ar_r[arp_r];

    always_comb begin
        state_nxt   = state_r;
        op_nxt      = op_r;
        acc_nxt     = acc_r;
        pc_nxt      = pc_r;
        arp_nxt     = arp_r;
        done_nxt    = 1'b0;
        rd_addr_nxt = rd_addr_r;
        addr_nxt    = {page_ptr, op_offset};
        for (int i = 0; i < `AZL_AR_NUM; i++) begin
            ar_nxt[i] = ar_r[i];
        end
        if (ar_wr_en) begin
            ar_nxt[ar_wr_sel] = ar_wr_data;
        end
        unique case (state_r)
            AZL_ST_IDLE: begin
                if (op_valid && op_code == AZL_OP_CLEAR_ACCUMULATOR) begin
                    acc_nxt  = `AZL_ACC_RST;
                    pc_nxt   = pc_r + `AZL_PC_STEP;
                    done_nxt = 1'b1;
                end else if (op_valid && op_code != AZL_OP_NONE) begin
                    op_nxt = op_code;
                    if (op_indirect) begin
                        addr_nxt = ar_r[arp_r];
                        ar_nxt[arp_r] = ar_step(ar_r[arp_r], ar_r[0], op_ind_mode);
                        if (op_arp_load) begin
                            arp_nxt = op_arp_new;
                        end
                    end
                    rd_addr_nxt = addr_nxt[`AZL_MEM_AW-1:0];
                    state_nxt   = AZL_ST_READ;
                end
            end
            AZL_ST_READ: begin
                // one cycle for the address register, one for ram read data
                state_nxt = AZL_ST_WRITE;
            end
            AZL_ST_WRITE: begin
                if (op_r == AZL_OP_LOAD_HIGH_CLEAR_LOW) begin
                    acc_nxt = {rd_word, {`AZL_WORD_W{1'b0}}};
                end else begin
                    // sign_extend_mode deliberately not consulted
                    acc_nxt = {{`AZL_WORD_W{1'b0}}, rd_word};
                end
                pc_nxt    = pc_r + `AZL_PC_STEP;
                done_nxt  = 1'b1;
                state_nxt = AZL_ST_IDLE;
            end
            default: begin
                state_nxt = AZL_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r   <= AZL_ST_IDLE;
            op_r      <= AZL_OP_NONE;
            acc_r     <= `AZL_ACC_RST;
            pc_r      <= `AZL_PC_RST;
            arp_r     <= '0;
            done_r    <= 1'b0;
            rd_addr_r <= '0;
            for (int i = 0; i < `AZL_AR_NUM; i++) begin
                ar_r[i] <= '0;
            end
        end else begin
            state_r   <= state_nxt;
            op_r      <= op_nxt;
            acc_r     <= acc_nxt;
            pc_r      <= pc_nxt;
            arp_r     <= arp_nxt;
            done_r    <= done_nxt;
            rd_addr_r <= rd_addr_nxt;
            for (int i = 0; i < `AZL_AR_NUM; i++) begin
                ar_r[i] <= ar_nxt[i];
            end
        end
    end

    logic unused_sign_ext;
    assign unused_sign_ext = sign_extend_mode;

    high_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state_r == AZL_ST_WRITE && op_r == AZL_OP_LOAD_HIGH_CLEAR_LOW)
        |=> acc_r[31:16] == $past(rd_word))
        else $error("high half not loaded from memory word");

    high_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state_r == AZL_ST_WRITE && op_r == AZL_OP_LOAD_HIGH_CLEAR_LOW)
        |=> acc_r[15:0] == 16'h0000 && op_done)
        else $error("low half not cleared on high load");

    arp_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (op_ready && op_valid && op_indirect && op_arp_load
         && op_code inside {AZL_OP_LOAD_HIGH_CLEAR_LOW, AZL_OP_LOAD_LOW_CLEAR_HIGH})
        |=> arp_r == $past(op_arp_new))
        else $error("pointer select not updated");

    low_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state_r == AZL_ST_WRITE && op_r == AZL_OP_LOAD_LOW_CLEAR_HIGH)
        |=> acc_r[15:0] == $past(rd_word))
        else $error("low half not loaded from memory word");

    low_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (op_ready && op_valid && op_code == AZL_OP_LOAD_LOW_CLEAR_HIGH)
        ##3 1'b1 |-> acc_r[31:16] == 16'h0000)
        else $error("high half not cleared on low load");

    no_sign_ext_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state_r == AZL_ST_WRITE && op_r == AZL_OP_LOAD_LOW_CLEAR_HIGH && sign_extend_mode)
        |=> acc_r == {16'h0000, $past(rd_word)})
        else $error("low load sign extended");

    clear_acc_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (op_ready && op_valid && op_code == AZL_OP_CLEAR_ACCUMULATOR)
        |=> acc_r == 32'h0000_0000 && pc_r == $past(pc_r) + 16'h0001 && op_done)
        else $error("clear did not zero or advance counter");

    load_timing_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (op_ready && op_valid && op_code == AZL_OP_LOAD_HIGH_CLEAR_LOW)
        |=> !op_done ##1 !op_done ##1 op_done && op_ready)
        else $error("load did not finish on third edge");

    // only the low ten bits of the word address reach the ram
    direct_addr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (op_ready && op_valid && !op_indirect
         && op_code inside {AZL_OP_LOAD_HIGH_CLEAR_LOW, AZL_OP_LOAD_LOW_CLEAR_HIGH})
        |=> rd_addr_r == {$past(page_ptr[2:0]), $past(op_offset)})
        else $error("direct address not formed from page and offset");

    ind_addr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (op_ready && op_valid && op_indirect
         && op_code inside {AZL_OP_LOAD_HIGH_CLEAR_LOW, AZL_OP_LOAD_LOW_CLEAR_HIGH})
        |=> rd_addr_r == $past(ar_value[9:0]))
        else $error("indirect address not taken from pointer");

    // the step overrides a same-cycle pointer write to the register that arp_r selects; such writes are left out here
    ptr_step_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (op_ready && op_valid && op_indirect && !ar_wr_en && op_ind_mode == AZL_IND_INC
         && op_code inside {AZL_OP_LOAD_HIGH_CLEAR_LOW, AZL_OP_LOAD_LOW_CLEAR_HIGH})
        |=> ar_r[$past(arp_r)] == $past(ar_value) + 16'h0001)
        else $error("pointer register not stepped");
endmodule

/* logic/azl_map.svh */
`ifndef AZL_MAP_SVH
`define AZL_MAP_SVH

`define AZL_ACC_W        32
`define AZL_WORD_W       16
`define AZL_PC_W         16
`define AZL_DMA_W        7
`define AZL_ARP_W        3
`define AZL_AR_NUM       8
`define AZL_PAGE_W       9
`define AZL_DADDR_W      16
`define AZL_MEM_AW       10
`define AZL_HI_LSB       16
`define AZL_ACC_RST      32'h0000_0000
`define AZL_PC_RST       16'h0000
`define AZL_PC_STEP      16'h0001
`define AZL_MEM_LAT      1

`endif

/* logic/azl_pkg.sv */
package azl_pkg;
    typedef enum logic [1:0] {
        AZL_OP_CLEAR_ACCUMULATOR = 2'b00,
        AZL_OP_LOAD_HIGH_CLEAR_LOW = 2'b01,
        AZL_OP_LOAD_LOW_CLEAR_HIGH = 2'b10,
        AZL_OP_NONE = 2'b11
    } azl_op_t;

    typedef enum logic [1:0] {
        AZL_ST_IDLE  = 2'b00,
        AZL_ST_READ  = 2'b01,
        AZL_ST_WRITE = 2'b10
    } azl_state_t;

    typedef enum logic [2:0] {
        AZL_IND_NONE = 3'b000,
        AZL_IND_INC  = 3'b001,
        AZL_IND_DEC  = 3'b010,
        AZL_IND_INC0 = 3'b011,
        AZL_IND_DEC0 = 3'b100
    } azl_ind_t;
endpackage

/* logic/azl_data_ram.sv */
`timescale 1ns/1ps
`include "azl_map.svh"

module azl_data_ram (
    input  wire logic                      core_clk,
    input  wire logic                      wr_en,
    input  wire logic [`AZL_MEM_AW-1:0]    wr_addr,
    input  wire logic [`AZL_WORD_W-1:0]    wr_data,
    input  wire logic [`AZL_MEM_AW-1:0]    rd_addr,
    output logic      [`AZL_WORD_W-1:0]    rd_data
);
    logic [`AZL_WORD_W-1:0] mem [0:(1<<`AZL_MEM_AW)-1];
    logic [`AZL_WORD_W-1:0] rd_data_nxt;

    always_comb begin
        rd_data_nxt = mem[rd_addr];
    end

    // no reset: plain storage, read data registered
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= rd_data_nxt;
    end
endmodule

/* bench/azl_mem_model.sv */
`timescale 1ns/1ps
`include "azl_map.svh"

module azl_mem_model (
    input  wire logic                core_clk,
    output logic                     mem_wr_en,
    output logic [`AZL_MEM_AW-1:0]   mem_wr_addr,
    output logic [`AZL_WORD_W-1:0]   mem_wr_data
);
    initial begin
        mem_wr_en = 1'b0;
        mem_wr_addr = '0;
        mem_wr_data = '0;
    end

    // lines turn to inverted values after a write so stale data never looks valid
    task automatic put(input logic [`AZL_MEM_AW-1:0] a, input logic [`AZL_WORD_W-1:0] d);
        @(posedge core_clk);
        #1;
        mem_wr_en = 1'b1;
        mem_wr_addr = a;
        mem_wr_data = d;
        @(posedge core_clk);
        #1;
        mem_wr_en = 1'b0;
        mem_wr_addr = ~a;
        mem_wr_data = ~d;
    endtask
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
`include "azl_map.svh"

module testbench;
    import azl_pkg::*;
    logic        core_clk = 0, reset_n = 0, op_valid = 0, op_indirect = 0, op_arp_load = 0;
    logic        sign_extend_mode = 0, ar_wr_en = 0, op_ready, op_done, mem_wr_en;
    azl_op_t     op_code = AZL_OP_NONE;
    azl_ind_t    op_ind_mode = AZL_IND_NONE;
    logic [6:0]  op_offset = '0;
    logic [2:0]  op_arp_new = '0, ar_wr_sel = '0, arp;
    logic [8:0]  page_ptr = 9'h005;
    logic [15:0] ar_wr_data = '0, mem_wr_data, pc, ar_value, exp_pc = '0;
    logic [9:0]  mem_wr_addr;
    logic [31:0] acc;
    int          bad_count = 0, samples_checked = 0;

    always #20 core_clk = ~core_clk;

    azl_mem_model mem (.core_clk(core_clk), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
                       .mem_wr_data(mem_wr_data));

    azl_acc_unit uut (.core_clk(core_clk), .reset_n(reset_n), .op_valid(op_valid),
        .op_ready(op_ready), .op_code(op_code), .op_indirect(op_indirect),
        .op_offset(op_offset), .op_ind_mode(op_ind_mode), .op_arp_load(op_arp_load),
        .op_arp_new(op_arp_new), .page_ptr(page_ptr), .sign_extend_mode(sign_extend_mode),
        .ar_wr_en(ar_wr_en), .ar_wr_sel(ar_wr_sel), .ar_wr_data(ar_wr_data),
        .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
        .op_done(op_done), .acc(acc), .pc(pc), .arp(arp), .ar_value(ar_value));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask

    // one request, then a bounded wait for op_done with its latency compared
    task automatic run_op(input azl_op_t c, input logic ind, input logic [6:0] off,
                          input int lat);
        int n;
        n = 1;
        @(posedge core_clk);
        #1;
        op_valid = 1'b1;
        op_code = c;
        op_indirect = ind;
        op_offset = off;
        @(posedge core_clk);
        #1;
        op_valid = 1'b0;
        op_code = AZL_OP_NONE;
        op_arp_load = 1'b0;
        exp_pc = exp_pc + 16'h0001;
        while (op_done !== 1'b1 && n < 8) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check(n, lat);
        check(pc, exp_pc);
    endtask

    task automatic t_high;
        mem.put(10'h2ff, 16'h1234);
        run_op(AZL_OP_LOAD_LOW_CLEAR_HIGH, 1'b0, 7'h7f, 3);
        check(acc, 32'h0000_1234);
        mem.put(10'h2ff, 16'h8001);
        run_op(AZL_OP_LOAD_HIGH_CLEAR_LOW, 1'b0, 7'h7f, 3);
        check(acc, 32'h8001_0000);
        $display("test high load finished");
    endtask

    task automatic t_low;
        sign_extend_mode = 1'b1;
        mem.put(10'h280, 16'hf7ff);
        run_op(AZL_OP_LOAD_LOW_CLEAR_HIGH, 1'b0, 7'h00, 3);
        check(acc, 32'h0000_f7ff);
        $display("test low load finished");
    endtask

    task automatic t_ind;
        @(posedge core_clk);
        #1;
        ar_wr_en = 1'b1;
        ar_wr_data = 16'h0123;
        @(posedge core_clk);
        #1;
        ar_wr_en = 1'b0;
        ar_wr_data = 16'hfedc;
        check(ar_value, 16'h0123);
        mem.put(10'h123, 16'hbeef);
        op_ind_mode = AZL_IND_INC;
        op_arp_load = 1'b1;
        op_arp_new = 3'h7;
        run_op(AZL_OP_LOAD_HIGH_CLEAR_LOW, 1'b1, 7'h00, 3);
        check(acc, 32'hbeef_0000);
        check(arp, 3'h7);
        @(posedge core_clk);
        #1;
        ar_wr_en = 1'b1;
        ar_wr_sel = 3'h7;
        ar_wr_data = 16'h0200;
        @(posedge core_clk);
        #1;
        ar_wr_en = 1'b0;
        mem.put(10'h200, 16'h8000);
        op_ind_mode = AZL_IND_INC0;
        run_op(AZL_OP_LOAD_LOW_CLEAR_HIGH, 1'b1, 7'h00, 3);
        check(acc, 32'h0000_8000);
        check(ar_value, 16'h0324);
        $display("test indirect load finished");
    endtask

    task automatic t_clear;
        run_op(AZL_OP_CLEAR_ACCUMULATOR, 1'b0, 7'h00, 1);
        check(acc, 32'h0);
        run_op(AZL_OP_LOAD_LOW_CLEAR_HIGH, 1'b0, 7'h00, 3);
        check(acc, 32'h0000_f7ff);
        run_op(AZL_OP_CLEAR_ACCUMULATOR, 1'b0, 7'h00, 1);
        check(acc, 32'h0);
        $display("test clear finished");
    endtask

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        // a whole run takes well under 200 cycles
        #(40 * 2000);
        bad_count++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        check(acc, 32'h0);
        t_high();
        t_low();
        t_ind();
        t_clear();
        print_verdict();
    end
endmodule
